//--- bench/lpms_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// CPU core and interrupt sources
// ----------------------------------------
module lpms_cpu_model #(
  parameter int WT = 4
) (
  input  wire logic  pclk,
  output logic       sleep_req,
  output logic       global_mask,
  output logic [18:0] wake_src,
  output logic       watch_tick
);
  int wcnt = 0; // Watch clock phase
  initial begin
    sleep_req   = 1'b0;
    global_mask = 1'b0;
    wake_src    = 19'h00000;
    watch_tick  = 1'b0;
  end
  // Watch clock runs free, so the tick never stops
  always @(posedge pclk) begin
    wcnt       <= (wcnt == WT - 1) ? 0 : wcnt + 1;
    watch_tick <= (wcnt == WT - 1);
  end
  // SLEEP instruction: one-cycle pulse
  task automatic sleep_op();
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask : sleep_op
  // Request levels stay until changed again
  task automatic irq(input logic [18:0] src, input logic msk);
    @(posedge pclk);
    wake_src    <= src;
    global_mask <= msk;
  endtask : irq
endmodule : lpms_cpu_model

//--- bench/lpms_sequencer_asserts.sv
`timescale 1ns/1ps
`include "lpms_defines.svh"
// ----------------------------------------
// Mode sequencer port checks
// ----------------------------------------
module lpms_sequencer_asserts #(
  parameter int NSRC = 19
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    ce,
  input wire logic                    reset_pin_n,
  input wire logic                    global_mask,
  input wire logic [NSRC-1:0]         wake_src,
  input wire lpms_pkg::lpms_mode_type mode,
  input wire logic                    exception_start,
  input wire logic                    clock_stable,
  input wire logic                    port_hold,
  input wire logic                    pins_hiz,
  input wire logic [7:0]              periph_run
);
  import lpms_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Settling ends in an active mode
  sequence settle_done_s;
    mode == lpms_settle ##1 mode inside {lpms_active_high, lpms_active_med};
  endsequence
  // Sleep ends in an active mode
  sequence sleep_wake_s;
    mode == lpms_sleep ##1 mode inside {lpms_active_high, lpms_active_med};
  endsequence
  boot_high_a: assert property (ce && reset_pin_n && mode == lpms_reset_st |=> mode == lpms_active_high)
    else $error("no active mode after reset");
  pin_reset_a: assert property (ce && !reset_pin_n |=> mode == lpms_reset_st)
    else $error("reset pin ignored");
  // Mask is sampled at the deciding edge, so one cycle is enough
  mask_hold_a: assert property (ce && reset_pin_n && global_mask && mode inside {lpms_sleep, lpms_watch}
    |=> mode == $past(mode))
    else $error("masked wake left sleep");
  watch_refuse_a: assert property (ce && reset_pin_n && mode == lpms_watch
    && (wake_src & `LPMS_WATCH_SRCS) == 0 |=> mode == lpms_watch)
    else $error("watch left without source");
  settle_exc_a: assert property (settle_done_s |-> exception_start && clock_stable)
    else $error("settle end without exception");
  sleep_exc_a: assert property (sleep_wake_s |-> exception_start)
    else $error("sleep wake without exception");
  exc_mode_a: assert property (exception_start |-> mode inside {lpms_active_high, lpms_active_med, lpms_subactive})
    else $error("exception in wrong mode");
  pin_hold_a: assert property (mode inside {lpms_watch, lpms_subsleep} |-> port_hold && !pins_hiz)
    else $error("ports not held");
  standby_hiz_a: assert property (mode == lpms_standby |-> pins_hiz && !clock_stable && periph_run == 8'h00)
    else $error("standby outputs wrong");
  watch_run_a: assert property (mode == lpms_watch |-> periph_run[7:5] == 3'b000 && periph_run[3:0] == 4'hf)
    else $error("watch peripherals wrong");
  subsleep_run_a: assert property (mode == lpms_subsleep |-> periph_run == 8'h9f)
    else $error("subsleep peripherals wrong");
endmodule : lpms_sequencer_asserts
bind lpms_sequencer lpms_sequencer_asserts #(.NSRC(NSRC)) lpms_sequencer_asserts_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .reset_pin_n(reset_pin_n), .global_mask(global_mask),
  .wake_src(wake_src), .mode(mode), .exception_start(exception_start), .clock_stable(clock_stable),
  .port_hold(port_hold), .pins_hiz(pins_hiz), .periph_run(periph_run)
);

//--- bench/lpms_sequencer_test.sv
`timescale 1ns/1ps
`include "lpms_defines.svh"
module lpms_sequencer_test;
  import lpms_pkg::*;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  localparam int WB = 8; // Short settle base keeps the run brief
  logic          pclk, presetn, ce, psel, penable, pwrite, reset_pin_n, e;
  logic          pready, pslverr, sleep_req, global_mask, watch_tick;
  logic          exception_start, cpu_tick, clock_stable, port_hold, pins_hiz;
  logic [7:0]    paddr, periph_run;
  logic [18:0]   wake_src;
  logic [31:0]   pwdata, prdata, v;
  lpms_mode_type mode;
  int            num_errors = 0, checked = 0, ticks = 0, excs = 0, t0, n;
  always #5 pclk = ~pclk;
  // Pre-edge values are read, so no race with the flops
  always @(posedge pclk) begin
    if (cpu_tick === 1'b1) ticks++;
    if (exception_start === 1'b1) excs++;
  end
  lpms_sequencer #(.WAIT_BASE(18'(WB))) lpms_sequencer_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .global_mask(global_mask), .wake_src(wake_src), .reset_pin_n(reset_pin_n),
    .watch_tick(watch_tick), .mode(mode), .exception_start(exception_start), .cpu_tick(cpu_tick),
    .clock_stable(clock_stable), .port_hold(port_hold), .pins_hiz(pins_hiz), .periph_run(periph_run)
  );
  lpms_cpu_model #(.WT(4)) lpms_cpu_model_i (
    .pclk(pclk), .sleep_req(sleep_req), .global_mask(global_mask), .wake_src(wake_src),
    .watch_tick(watch_tick)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // One transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Pre-edge values at each rising edge; only the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q       = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, a, d, q, er);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        er;
    apb(1'b0, a, 32'h0, q, er);
    chk(nm, q, x);
  endtask : rdchk
  // Wait a bounded time for a mode; pre delays a refusal check
  task automatic go(input lpms_mode_type m, input int lim, input int pre = 0);
    int k;
    k = 0;
    repeat (pre) @(negedge pclk);
    while (mode !== m && k < lim) begin
      @(negedge pclk);
      k++;
    end
    chk("mode", 32'(mode), 32'(m));
  endtask : go
  // Sleep, wake on src, expect one exception
  task automatic nap(input lpms_mode_type mid, input logic [18:0] src, input lpms_mode_type dst, input int lim);
    int x0;
    x0 = excs;
    lpms_cpu_model_i.sleep_op();
    go(mid, 40);
    lpms_cpu_model_i.irq(src, 1'b0);
    go(dst, lim);
    // The pulse is counted at the edge after the mode change
    @(negedge pclk);
    chk("exception", excs - x0, 1);
    lpms_cpu_model_i.irq(19'h0, 1'b0);
  endtask : nap
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Watchdog: the tests need about 3 us
  initial begin
    #50000;
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    ce          = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    reset_pin_n = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    go(lpms_active_high, 4);
    rdchk("status", `LPMS_OFF_STATUS, 32'h21);
    rdchk("ctrl1", `LPMS_OFF_CTRL_ONE, 32'h0);
    wr(`LPMS_OFF_ENABLE, 32'hffffffff);
    rdchk("enable", `LPMS_OFF_ENABLE, 32'h7ffff);
    apb(1'b0, 8'h20, 32'h0, v, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("test registers done");
    // Masked, then disabled, then real wake
    lpms_cpu_model_i.sleep_op();
    go(lpms_sleep, 8);
    lpms_cpu_model_i.irq(19'h00001, 1'b1);
    go(lpms_sleep, 1, 12);
    wr(`LPMS_OFF_ENABLE, 32'h0);
    lpms_cpu_model_i.irq(19'h00001, 1'b0);
    go(lpms_sleep, 1, 12);
    wr(`LPMS_OFF_ENABLE, 32'h7ffff);
    go(lpms_active_high, 8);
    lpms_cpu_model_i.irq(19'h0, 1'b0);
    wr(`LPMS_OFF_CTRL_TWO, 32'h04);
    nap(lpms_sleep, 19'h00400, lpms_active_med, 8);
    $display("test sleep done");
    // Medium divider 0 gives a tick every second cycle
    t0 = ticks;
    repeat (32) @(negedge pclk);
    chk("medium ticks", ticks - t0, 16);
    nap(lpms_sleep, 19'h00002, lpms_active_med, 8);
    wr(`LPMS_OFF_CTRL_ONE, 32'h90);
    lpms_cpu_model_i.sleep_op();
    go(lpms_standby, 8);
    chk("hiz", {31'h0, pins_hiz}, 32'h1);
    t0 = excs;
    lpms_cpu_model_i.irq(19'h00400, 1'b0);
    go(lpms_settle, 8);
    n = 0;
    while (mode === lpms_settle && n < 64) begin
      @(negedge pclk);
      n++;
    end
    // Half-state early entry tolerated as one cycle
    chk("settle", 32'(n >= 2 * WB - 1 && n <= 2 * WB + 1), 32'h1);
    go(lpms_active_med, 2);
    @(negedge pclk);
    chk("exception", excs - t0, 1);
    lpms_cpu_model_i.irq(19'h0, 1'b0);
    $display("test medium done");
    // Watch entry, refused source, wake to subactive
    wr(`LPMS_OFF_TIMER_A, 32'h08);
    wr(`LPMS_OFF_CTRL_ONE, 32'h80);
    lpms_cpu_model_i.sleep_op();
    go(lpms_watch, 8);
    chk("watch run", {24'h0, periph_run}, 32'h0f);
    lpms_cpu_model_i.irq(19'h00002, 1'b0);
    go(lpms_watch, 1, 12);
    wr(`LPMS_OFF_CTRL_ONE, 32'h88);
    lpms_cpu_model_i.irq(19'h00001, 1'b0);
    go(lpms_subactive, 8);
    lpms_cpu_model_i.irq(19'h0, 1'b0);
    // Subactive divider 1: four watch ticks per cpu tick
    wr(`LPMS_OFF_CTRL_TWO, 32'h05);
    repeat (20) @(negedge pclk);
    t0 = ticks;
    repeat (64) @(negedge pclk);
    chk("sub ticks", ticks - t0, 4);
    wr(`LPMS_OFF_CTRL_ONE, 32'h08);
    nap(lpms_subsleep, 19'h00020, lpms_subactive, 50);
    $display("test watch_sub done");
    // Reset pin from watch
    wr(`LPMS_OFF_CTRL_ONE, 32'h88);
    lpms_cpu_model_i.sleep_op();
    go(lpms_watch, 40);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    go(lpms_reset_st, 3);
    @(posedge pclk);
    reset_pin_n <= 1'b1;
    go(lpms_active_high, 3);
    rdchk("ctrl1", `LPMS_OFF_CTRL_ONE, 32'h0);
    $display("test reset_pin done");
    close_out();
  end
endmodule : lpms_sequencer_test

//--- design/lpms_divider.sv
`timescale 1ns/1ps
// ----------------------------------------
// Tick divider: one out tick per 2^(sel+1) in ticks
// ----------------------------------------
module lpms_divider #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] sel,
  output logic                  tick_out
);
  logic [7:0] count; // Free running count of input ticks
  logic [7:0] limit; // Last count value before wrap

  // Limit from select, kept combinational
  always_comb begin
    limit = 8'((9'd2 << sel) - 9'd1);
  end

  // Count and emit a tick on wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (ce) begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count >= limit) begin
          count    <= 8'h00;
          tick_out <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule : lpms_divider

//--- design/lpms_sequencer.sv
// Operation
// - SLEEP with standby and timer select: watch
// - Watch keeps only timers, counter, display
// - Watch/subsleep retain state, hold port pins
// - Watch wakes on its sources or reset
// - Watch wake target from low/medium bits
// - Settle, then stable clock, then exception (code raises clock_stable and exception_start on the same edge)
// - Global mask or disabled source blocks wake
// - Subactive SLEEP with low-speed enters subsleep
// - Subsleep stops only converter and PWM
// - Subsleep wakes on listed sources or reset
// - Subsleep wake returns to subactive, exception
// - Subsleep wake synchronised, two subclock delay
// - Subactive clock is watch clock /2,/4,/8 (divider field value 3 also gives /16)
// - Medium-on wakes into active medium-speed
// - Medium entry may come half state early
// - Medium SLEEP with standby select: standby
// - Medium SLEEP with both clear: sleep
// - Reset pin low forces reset state
// - Medium clock follows medium divider field
// - Active SLEEP standby, pins high impedance
`timescale 1ns/1ps
`include "lpms_defines.svh"
module lpms_sequencer #(
  parameter int          NSRC      = `LPMS_SRC_COUNT,
  parameter logic [17:0] WAIT_BASE = 18'(`LPMS_WAIT_LONG_BASE)
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sleep_req,
  input  wire logic                 global_mask,
  input  wire logic [NSRC-1:0]      wake_src,
  input  wire logic                 reset_pin_n,
  input  wire logic                 watch_tick,
  output lpms_pkg::lpms_mode_type   mode,
  output logic                      exception_start,
  output logic                      cpu_tick,
  output logic                      clock_stable,
  output logic                      port_hold,
  output logic                      pins_hiz,
  output logic [7:0]                periph_run
);
  import lpms_pkg::*;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0]      ctrl_one;      // Standby, low-speed, wait, medium divider
  logic [7:0]      ctrl_two;      // Medium-on, subactive divider, display
  logic [7:0]      timer_a;       // Timer A mode, bit 3 selects clock
  logic [NSRC-1:0] enable;        // Per-source wake enable
  lpms_mode_type   next_mode;     // Mode chosen this cycle
  lpms_mode_type   settle_target; // Active mode after settling
  logic [17:0]     settle_count;  // Remaining settling states
  logic [17:0]     wait_states;   // Settle length from wait field
  logic [NSRC-1:0] pending;       // Enabled, unmasked requests
  logic [NSRC-1:0] sub_synced;    // Requests after subclock sync
  logic            sub_tick;      // Subactive CPU tick
  logic            med_tick;      // Medium CPU tick
  logic            wake_now;      // Wake into an active or subactive mode this cycle
  logic            enter_settle;  // Wake needs oscillator settling

  // Field views
  logic            stby;
  logic            low_speed_on;
  logic            medium_speed_on;
  logic            tclk;
  logic [2:0]      wait_sel;
  logic [1:0]      mdiv;
  logic [1:0]      sdiv;

  assign stby     = ctrl_one[`LPMS_C1_STBY];
  assign low_speed_on     = ctrl_one[`LPMS_C1_LOW_SPEED_ON];
  assign wait_sel = ctrl_one[`LPMS_C1_WAIT_LSB +: 3];
  assign mdiv     = ctrl_one[`LPMS_C1_MDIV_LSB +: 2];
  assign medium_speed_on     = ctrl_two[`LPMS_C2_MEDIUM_SPEED_ON];
  assign sdiv     = ctrl_two[`LPMS_C2_SDIV_LSB +: 2];
  assign tclk     = timer_a[`LPMS_TA_CLKSEL];

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Register index from byte address; used by read and write paths
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      `LPMS_OFF_CTRL_ONE: reg_index = 3'd1;
      `LPMS_OFF_CTRL_TWO: reg_index = 3'd2;
      `LPMS_OFF_TIMER_A:  reg_index = 3'd3;
      `LPMS_OFF_ENABLE:   reg_index = 3'd4;
      `LPMS_OFF_STATUS:   reg_index = 3'd5;
      default:            reg_index = 3'd0;
    endcase
  endfunction : reg_index

  // Active target after a wake, shared by several modes
  function automatic lpms_mode_type active_target(input logic m);
    active_target = m ? lpms_active_med : lpms_active_high;
  endfunction : active_target

  // ----------------------------------------
  // Clock dividers and wake synchroniser
  // ----------------------------------------
  // watch divider
  lpms_divider #(.WIDTH(2)) u_sub_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .tick_in  (watch_tick),
    .sel      (sdiv),
    .tick_out (sub_tick)
  );

  lpms_divider #(.WIDTH(2)) u_med_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .tick_in  (1'b1),
    .sel      (mdiv),
    .tick_out (med_tick)
  );

  lpms_wake_sync #(.N(NSRC)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .step    (sub_tick),
    .req_in  (pending),
    .req_out (sub_synced)
  );

  // ----------------------------------------
  // Wake qualification
  // ----------------------------------------
  // mask and enables
  always_comb begin
    pending = global_mask ? '0 : (wake_src & enable);
  end

  // Settle length; long choices scale a parameter so sims can shorten
  always_comb begin
    case (wait_sel)
      3'd0:    wait_states = WAIT_BASE;
      3'd1:    wait_states = 18'(WAIT_BASE << 1);
      3'd2:    wait_states = 18'(WAIT_BASE << 2);
      3'd3:    wait_states = 18'(WAIT_BASE << 3);
      3'd4:    wait_states = 18'(WAIT_BASE << 4);
      3'd5:    wait_states = `LPMS_WAIT_SHORT_A;
      3'd6:    wait_states = `LPMS_WAIT_SHORT_B;
      default: wait_states = `LPMS_WAIT_SHORT_C;
    endcase
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  always_comb begin
    next_mode    = mode;
    wake_now     = 1'b0;
    enter_settle = 1'b0;
    case (mode)
      lpms_reset_st: next_mode = lpms_active_high;
      lpms_active_high, lpms_active_med: begin
        if (sleep_req) begin
          if (stby && tclk) begin
            next_mode = lpms_watch;
          end else if (stby && !low_speed_on) begin
            next_mode = lpms_standby;
          end else if (!stby) begin
            next_mode = lpms_sleep;
          end
        end
      end
      lpms_subactive: begin
        if (sleep_req && tclk) begin
          if (stby) begin
            next_mode = lpms_watch;
          end else if (low_speed_on) begin
            next_mode = lpms_subsleep;
          end
        end
      end
      lpms_sleep: begin
        if (|pending) begin
          next_mode = active_target(medium_speed_on && !low_speed_on);
          wake_now  = 1'b1;
        end
      end
      lpms_standby: begin
        if (|(pending & `LPMS_STANDBY_SRCS)) begin
          enter_settle = 1'b1;
          next_mode    = lpms_settle;
        end
      end
      lpms_watch: begin
        if (|(pending & `LPMS_WATCH_SRCS)) begin
          if (low_speed_on) begin
            next_mode = lpms_subactive;
            wake_now  = 1'b1;
          end else begin
            enter_settle = 1'b1;
            next_mode    = lpms_settle;
          end
        end
      end
      lpms_subsleep: begin
        if (sub_tick && |(sub_synced & `LPMS_SUBSLEEP_SRCS)) begin
          next_mode = lpms_subactive;
          wake_now  = 1'b1;
        end
      end
      lpms_settle: begin
        if (settle_count <= 18'd1) begin
          next_mode = settle_target;
          wake_now  = 1'b1;
        end
      end
      default: next_mode = lpms_reset_st;
    endcase
    if (!reset_pin_n) begin
      next_mode    = lpms_reset_st;
      wake_now     = 1'b0;
      enter_settle = 1'b0;
    end
  end

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  // medium entry is cycle-exact here, half-state early is allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= lpms_reset_st;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  // Settling counter and its destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count  <= 18'd0;
      settle_target <= lpms_active_high;
    end else if (ce) begin
      if (enter_settle) begin
        settle_count  <= wait_states;
        settle_target <= active_target(medium_speed_on && !low_speed_on);
      end else if (mode == lpms_settle && settle_count != 18'd0) begin
        settle_count <= settle_count - 18'd1;
      end
    end
  end

  // Exception handling start, one pulse per accepted wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exception_start <= 1'b0;
    end else if (ce) begin
      exception_start <= wake_now;
    end
  end

  // ----------------------------------------
  // Clocking and pin outputs
  // ----------------------------------------
  // CPU tick by mode; registered so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_tick     <= 1'b0;
      clock_stable <= 1'b1;
    end else if (ce) begin
      case (next_mode)
        lpms_active_high: cpu_tick <= 1'b1;
        lpms_active_med:  cpu_tick <= med_tick;
        lpms_subactive:   cpu_tick <= sub_tick;
        default:          cpu_tick <= 1'b0;
      endcase
      clock_stable <= !(next_mode inside {lpms_standby, lpms_watch, lpms_settle});
    end
  end

  // Port hold and high impedance; standby floats, watch, subsleep and settle hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_hold <= 1'b0;
      pins_hiz  <= 1'b0;
    end else if (ce) begin
      port_hold <= next_mode inside {lpms_watch, lpms_subsleep, lpms_settle};
      pins_hiz  <= next_mode == lpms_standby;
    end
  end

  // Peripheral run enables:
  // 0 timer A, 1 timer F, 2 timer G, 3 event counter, 4 display,
  // 5 converter, 6 PWM, 7 all other peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_run <= 8'hff;
    end else if (ce) begin
      case (next_mode)
        lpms_watch, lpms_settle: periph_run <= {3'b000, ctrl_two[`LPMS_C2_DISP], 4'hf};
        lpms_subsleep: periph_run <= 8'h9f;
        lpms_standby:  periph_run <= 8'h00;
        default:       periph_run <= 8'hff;
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Writes take effect in the access phase, which always completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one <= `LPMS_RST_CTRL_ONE;
      ctrl_two <= `LPMS_RST_CTRL_TWO;
      timer_a  <= `LPMS_RST_TIMER_A;
      enable   <= NSRC'(`LPMS_RST_ENABLE);
    end else if (ce && !reset_pin_n) begin
      ctrl_one <= `LPMS_RST_CTRL_ONE;
      ctrl_two <= `LPMS_RST_CTRL_TWO;
      timer_a  <= `LPMS_RST_TIMER_A;
      enable   <= NSRC'(`LPMS_RST_ENABLE);
    end else if (ce && psel && penable && pready && pwrite) begin
      case (reg_index(paddr))
        3'd1:    ctrl_one <= pwdata[7:0];
        3'd2:    ctrl_two <= pwdata[7:0];
        3'd3:    timer_a  <= pwdata[7:0];
        3'd4:    enable   <= pwdata[NSRC-1:0];
        default: ;
      endcase
    end
  end

  // Ready, error and read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (reg_index(paddr) == 3'd0);
      case (reg_index(paddr))
        3'd1:    prdata <= {24'h000000, ctrl_one};
        3'd2:    prdata <= {24'h000000, ctrl_two};
        3'd3:    prdata <= {24'h000000, timer_a};
        3'd4:    prdata <= 32'(enable);
        3'd5:    prdata <= {26'h0000000, clock_stable, port_hold, mode};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : lpms_sequencer

//--- design/lpms_wake_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser, stepped by a tick
// ----------------------------------------
module lpms_wake_sync #(
  parameter int N = 19
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         step,
  input  wire logic [N-1:0] req_in,
  output logic [N-1:0]      req_out
);
  logic [N-1:0] stage_one; // First stage, read only by second

  // Per-bit pair, generated so every source gets its own flops
  for (genvar i = 0; i < N; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage_one[i] <= 1'b0;
        req_out[i]   <= 1'b0;
      end else if (ce && step) begin
        stage_one[i] <= req_in[i];
        req_out[i]   <= stage_one[i];
      end
    end
  end
endmodule : lpms_wake_sync

//--- shared/lpms_defines.svh
`ifndef LPMS_DEFINES_SVH
`define LPMS_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LPMS_OFF_CTRL_ONE   8'h00
`define LPMS_OFF_CTRL_TWO   8'h04
`define LPMS_OFF_TIMER_A    8'h08
`define LPMS_OFF_ENABLE     8'h0c
`define LPMS_OFF_STATUS     8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPMS_C1_STBY        7
`define LPMS_C1_LOW_SPEED_ON        3
`define LPMS_C1_WAIT_LSB    4
`define LPMS_C1_MDIV_LSB    0
`define LPMS_C2_MEDIUM_SPEED_ON        2
`define LPMS_C2_SDIV_LSB    0
`define LPMS_C2_DISP        4
`define LPMS_TA_CLKSEL      3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPMS_RST_CTRL_ONE   8'h00
`define LPMS_RST_CTRL_TWO   8'h00
`define LPMS_RST_TIMER_A    8'h00
`define LPMS_RST_ENABLE     19'h00000
// ----------------------------------------
// Wake source groups (bit per source)
// ----------------------------------------
`define LPMS_SRC_COUNT      19
`define LPMS_WATCH_SRCS     19'h7fc0d
`define LPMS_SUBSLEEP_SRCS  19'h7ffff
`define LPMS_STANDBY_SRCS   19'h7fe00
// ----------------------------------------
// Settling counts in states
// ----------------------------------------
`define LPMS_WAIT_LONG_BASE 8192
`define LPMS_WAIT_SHORT_A   18'd2
`define LPMS_WAIT_SHORT_B   18'd8
`define LPMS_WAIT_SHORT_C   18'd16
`endif

//--- shared/lpms_pkg.sv
package lpms_pkg;
  // Operating modes of the sequencer
  typedef enum logic [3:0] {
    lpms_reset_st    = 4'b0000,
    lpms_active_high = 4'b0001,
    lpms_active_med  = 4'b0010,
    lpms_subactive   = 4'b0011,
    lpms_sleep       = 4'b0100,
    lpms_subsleep    = 4'b0101,
    lpms_watch       = 4'b0110,
    lpms_standby     = 4'b0111,
    lpms_settle      = 4'b1000
  } lpms_mode_type;
endpackage : lpms_pkg
